// File: pkg/mgtp_pkg.sv
`default_nettype none
// Shared constants and carriers for the management port block.
package mgtp_pkg;
	// Wishbone byte offsets of the local registers.
	localparam logic [3:0] WB_CTRL      = 4'h0;
	localparam logic [3:0] WB_STATUS    = 4'h4;
	localparam logic [3:0] WB_IRQ_STAT  = 4'h8;
	localparam logic [3:0] WB_IRQ_MASK  = 4'hc;
	// Control register fields and reset value.
	localparam int         CTRL_TEST_PORT_BIT = 0;
	localparam logic [0:0] CTRL_RST           = 1'h0;
	// Interrupt bit positions and reset values.
	localparam int         IRQ_WRITE_BIT = 0;
	localparam int         IRQ_READ_BIT  = 1;
	localparam int         IRQ_PERR_BIT  = 2;
	localparam int         IRQ_W         = 3;
	localparam logic [2:0] IRQ_RST       = 3'h0;
	// Management frame format.
	localparam logic [5:0] PREAMBLE_BITS = 6'h20;
	localparam logic [3:0] HDR_LAST      = 4'hb;
	localparam logic [3:0] DATA_LAST     = 4'hf;
	localparam logic [1:0] OP_WRITE      = 2'h1;
	localparam logic [1:0] OP_READ       = 2'h2;
	// Management register addresses, fields and reset value.
	localparam logic [4:0]  REG_PAT_SEL  = 5'h00;
	localparam logic [4:0]  REG_PWR      = 5'h01;
	localparam logic [4:0]  REG_PAT_EN   = 5'h0b;
	localparam int          PWR_DOWN_BIT = 15;
	localparam logic [15:0] PAT_EN_MASK  = 16'h30c0;
	localparam logic [15:0] CHAN_REG_RST = 16'h0000;
	// Frame header as shifted in: opcode, port address, register address.
	typedef struct packed {
		logic [1:0] op;
		logic [4:0] port;
		logic [4:0] regad;
	} mgtp_hdr_t;
	// Per-channel management registers.
	typedef struct packed {
		logic [15:0] pat_sel;
		logic [15:0] pwr;
		logic [15:0] pat_en;
	} mgtp_chan_regs_t;
	// Frame receiver states.
	typedef enum logic [4:0] {
		MF_IDLE  = 5'h01,
		MF_START = 5'h02,
		MF_HDR   = 5'h04,
		MF_TA    = 5'h08,
		MF_DATA  = 5'h10
	} mgtp_state_t;
endpackage
`default_nettype wire

// File: src/mgtp_mgmt_port.sv
// Contract
// - Answer a frame only when port field bits 4:1 match strap bits 4:1.
// - Port field bit 0 picks channel: 0 is channel A, 1 is channel B.
// - Strap bit 0 is ignored for matching; the board ties it low.
// - With pattern test on, ok flag is high when error free, low on error.
// - Register 0 bits 3:0 choose which channel, side and lane the flag reports.
// - While the device reset pin is low the ok flag is driven low.
// - The ok flag floats in register power down and pin power down.
// - Register power down keeps the port serving; reset and pin power down float data.
// - Some status bits are unreliable in power down; software must not trust them.
// - Management clock clocks the port; the data line carries data both ways.
// - Test data out floats when unused, in reset and in both power downs.
// - Test data in pull-up is off in pin power down, on in register power down.
// - Pattern test is on when the pin or any register enable bit is set.
`default_nettype none
module mgtp_mgmt_port (
	// System.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	// Device pins.
	input  wire logic        device_reset_low_i,
	input  wire logic        power_down_chan_a_low_i,
	input  wire logic        power_down_chan_b_low_i,
	input  wire logic        pattern_test_enable_i,
	input  wire logic [4:0]  port_addr_strap_i,
	input  wire logic [15:0] lane_ok_i,
	// Management link.
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	// Status and test pins.
	output logic             prbs_ok_flag_o,
	output logic             prbs_ok_flag_oe_o,
	output logic             tdo_oe_o,
	output logic             tdi_pullup_en_o,
	output logic      [1:0]  pattern_run_o
);

	logic [26:0]               s1_ff;
	logic [26:0]               s2_ff;
	logic                      dev_rst_n_s;
	logic                      pda_s;
	logic                      pdb_s;
	logic                      pten_s;
	logic [4:0]                strap_s;
	logic                      mdc_s;
	logic                      mdio_s;
	logic [15:0]               lane_ok_s;
	logic                      core_rst;
	logic                      pin_pd;
	logic                      reg_pd;
	logic                      mgmt_off;
	logic                      mdc_q_ff;
	logic                      mdc_rise;
	mgtp_pkg::mgtp_state_t     state_ff;
	logic [5:0]                pre_cnt_ff;
	logic [3:0]                bit_cnt_ff;
	mgtp_pkg::mgtp_hdr_t       hdr_ff;
	mgtp_pkg::mgtp_hdr_t       nxt_hdr;
	logic                      hit_calc;
	logic                      hit_ff;
	logic                      rd_ff;
	logic [15:0]               sh_ff;
	logic [15:0]               rd_word;
	logic                      wr_stb_ff;
	logic [15:0]               wdata_ff;
	logic                      rd_evt_ff;
	mgtp_pkg::mgtp_chan_regs_t regs_ff [2];
	logic [3:0]                pat_sel;
	logic                      pat_any;
	logic                      nxt_ok;
	logic                      perr_evt;
	logic                      wb_req;
	logic                      wb_wr;
	logic [31:0]               rd_mux;
	logic [0:0]                ctrl_ff;
	logic [2:0]                irq_stat_ff;
	logic [2:0]                irq_mask_ff;
	logic [2:0]                irq_evt;

	// Every pin passes two flip-flops; only the second stage is read below.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_ff <= 27'h0;
			s2_ff <= 27'h0;
		end
		else
		begin
			s1_ff <= {device_reset_low_i, power_down_chan_a_low_i, power_down_chan_b_low_i,
				pattern_test_enable_i, port_addr_strap_i, mdc_i, mdio_i, lane_ok_i};
			s2_ff <= s1_ff;
		end
	end

	// Synchronised pin levels and derived operating modes.
	assign dev_rst_n_s = s2_ff[26];
	assign pda_s       = s2_ff[25];
	assign pdb_s       = s2_ff[24];
	assign pten_s      = s2_ff[23];
	assign strap_s     = s2_ff[22:18];
	assign mdc_s       = s2_ff[17];
	assign mdio_s      = s2_ff[16];
	assign lane_ok_s   = s2_ff[15:0];
	assign core_rst    = rst_i | ~dev_rst_n_s;
	assign pin_pd      = ~pda_s & ~pdb_s;
	assign reg_pd      = regs_ff[0].pwr[mgtp_pkg::PWR_DOWN_BIT] & regs_ff[1].pwr[mgtp_pkg::PWR_DOWN_BIT];
	// Register power down is left out here so the port keeps serving in it.
	assign mgmt_off    = core_rst | pin_pd;
	assign mdc_rise    = mdc_s & ~mdc_q_ff;

	// Edge history of the management clock.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mdc_q_ff <= 1'b0;
		else
			mdc_q_ff <= mdc_s;
	end

	// Header decode; strap bit 0 takes no part in the match.
	assign nxt_hdr  = mgtp_pkg::mgtp_hdr_t'({hdr_ff[10:0], mdio_s});
	assign hit_calc = (nxt_hdr.port[4:1] == strap_s[4:1]);

	// Read data comes from the channel that port field bit 0 selects.
	always_comb
	begin
		rd_word = 16'h0000;
		case (hdr_ff.regad)
			mgtp_pkg::REG_PAT_SEL: rd_word = regs_ff[hdr_ff.port[0]].pat_sel;
			mgtp_pkg::REG_PWR:     rd_word = regs_ff[hdr_ff.port[0]].pwr;
			mgtp_pkg::REG_PAT_EN:  rd_word = regs_ff[hdr_ff.port[0]].pat_en;
			default:               rd_word = 16'h0000;
		endcase
	end

	// Frame receiver; it moves on a sampled rising management clock edge, and its strobes drop one cycle later.
	always_ff @(posedge clk_i)
	begin
		if (mgmt_off)
		begin
			state_ff   <= mgtp_pkg::MF_IDLE;
			pre_cnt_ff <= 6'h00;
			bit_cnt_ff <= 4'h0;
			hdr_ff     <= mgtp_pkg::mgtp_hdr_t'(12'h000);
			sh_ff      <= 16'h0000;
			hit_ff     <= 1'b0;
			rd_ff      <= 1'b0;
			mdio_o     <= 1'b0;
			mdio_oe_o  <= 1'b0;
			wr_stb_ff  <= 1'b0;
			wdata_ff   <= 16'h0000;
			rd_evt_ff  <= 1'b0;
		end
		else
		begin
			wr_stb_ff <= 1'b0;
			rd_evt_ff <= 1'b0;
			if (mdc_rise)
			begin
				case (state_ff)
					// Count preamble ones; a zero after a full preamble opens the start field.
					mgtp_pkg::MF_IDLE:
					begin
						if (mdio_s)
						begin
							if (pre_cnt_ff != mgtp_pkg::PREAMBLE_BITS)
								pre_cnt_ff <= pre_cnt_ff + 6'h01;
						end
						else
						begin
							if (pre_cnt_ff == mgtp_pkg::PREAMBLE_BITS)
								state_ff <= mgtp_pkg::MF_START;
							pre_cnt_ff <= 6'h00;
						end
					end
					mgtp_pkg::MF_START:
					begin
						bit_cnt_ff <= 4'h0;
						state_ff   <= mdio_s ? mgtp_pkg::MF_HDR : mgtp_pkg::MF_IDLE;
					end
					mgtp_pkg::MF_HDR:
					begin
						hdr_ff     <= nxt_hdr;
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
						if (bit_cnt_ff == mgtp_pkg::HDR_LAST)
						begin
							state_ff   <= mgtp_pkg::MF_TA;
							bit_cnt_ff <= 4'h0;
							hit_ff     <= hit_calc;
							rd_ff      <= hit_calc && (nxt_hdr.op == mgtp_pkg::OP_READ);
						end
					end
					// First turnaround bit floats; on a read the device drives the second one low.
					mgtp_pkg::MF_TA:
					begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
						if (bit_cnt_ff == 4'h0)
						begin
							mdio_oe_o <= rd_ff;
							mdio_o    <= 1'b0;
						end
						else
						begin
							state_ff   <= mgtp_pkg::MF_DATA;
							bit_cnt_ff <= 4'h0;
							mdio_o     <= rd_ff & rd_word[15];
							sh_ff      <= {rd_word[14:0], 1'b0};
						end
					end
					mgtp_pkg::MF_DATA:
					begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
						sh_ff      <= {sh_ff[14:0], rd_ff ? 1'b0 : mdio_s};
						mdio_o     <= rd_ff & sh_ff[15];
						if (bit_cnt_ff == mgtp_pkg::DATA_LAST)
						begin
							state_ff   <= mgtp_pkg::MF_IDLE;
							bit_cnt_ff <= 4'h0;
							mdio_oe_o  <= 1'b0;
							mdio_o     <= 1'b0;
							rd_evt_ff  <= rd_ff;
							wr_stb_ff  <= hit_ff && (hdr_ff.op == mgtp_pkg::OP_WRITE);
							wdata_ff   <= {sh_ff[14:0], mdio_s};
						end
					end
					default: state_ff <= mgtp_pkg::MF_IDLE;
				endcase
			end
		end
	end

	// Per-channel registers and pattern enables; a write lands only in its channel.
	for (genvar c = 0; c < 2; c++)
	begin : g_chan
		always_ff @(posedge clk_i)
		begin
			if (core_rst)
				regs_ff[c] <= {3{mgtp_pkg::CHAN_REG_RST}};
			else if (wr_stb_ff && (hdr_ff.port[0] == 1'(c)))
			begin
				case (hdr_ff.regad)
					mgtp_pkg::REG_PAT_SEL: regs_ff[c].pat_sel <= wdata_ff;
					mgtp_pkg::REG_PWR:     regs_ff[c].pwr     <= wdata_ff;
					mgtp_pkg::REG_PAT_EN:  regs_ff[c].pat_en  <= wdata_ff;
					default:               regs_ff[c]         <= regs_ff[c];
				endcase
			end
		end

		always_ff @(posedge clk_i)
		begin
			if (core_rst)
				pattern_run_o[c] <= 1'b0;
			else
				pattern_run_o[c] <= pten_s | (|(regs_ff[c].pat_en & mgtp_pkg::PAT_EN_MASK));
		end
	end

	// Pass flag source; the selector lives in channel A's register 0.
	assign pat_sel  = regs_ff[0].pat_sel[3:0];
	assign pat_any  = pten_s | (|((regs_ff[0].pat_en | regs_ff[1].pat_en) & mgtp_pkg::PAT_EN_MASK));
	assign nxt_ok   = pat_any & lane_ok_s[pat_sel];
	assign perr_evt = pat_any & prbs_ok_flag_o & ~nxt_ok & prbs_ok_flag_oe_o;

	// Pass flag pin: low in reset, floating in either power down.
	always_ff @(posedge clk_i)
	begin
		if (core_rst)
		begin
			prbs_ok_flag_o    <= 1'b0;
			prbs_ok_flag_oe_o <= 1'b1;
		end
		else if (pin_pd || reg_pd)
		begin
			prbs_ok_flag_o    <= 1'b0;
			prbs_ok_flag_oe_o <= 1'b0;
		end
		else
		begin
			prbs_ok_flag_o    <= nxt_ok;
			prbs_ok_flag_oe_o <= 1'b1;
		end
	end

	// Test pins: output enable only for an active test port outside reset and power down.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tdo_oe_o        <= 1'b0;
			tdi_pullup_en_o <= 1'b0;
		end
		else
		begin
			tdo_oe_o        <= ctrl_ff[0] & ~core_rst & ~pin_pd & ~reg_pd;
			tdi_pullup_en_o <= ~pin_pd;
		end
	end

	// Wishbone: ack one cycle after the request, write applied at the ack edge.
	assign wb_req = wb_cyc_i & wb_stb_i;
	assign wb_wr  = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];

	// Status reflects live power-down state, and the pass flag bit reads 0 while powered down.
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			mgtp_pkg::WB_CTRL:     rd_mux = {31'h0, ctrl_ff};
			mgtp_pkg::WB_STATUS:   rd_mux = {22'h0, strap_s, prbs_ok_flag_o, pat_any, reg_pd, pin_pd, core_rst};
			mgtp_pkg::WB_IRQ_STAT: rd_mux = {29'h0, irq_stat_ff};
			mgtp_pkg::WB_IRQ_MASK: rd_mux = {29'h0, irq_mask_ff};
			default:               rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus answer registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req & ~wb_ack_o;
			if (wb_req && !wb_ack_o)
				wb_dat_o <= rd_mux;
		end
	end

	// Software-written control and mask registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_ff     <= mgtp_pkg::CTRL_RST;
			irq_mask_ff <= mgtp_pkg::IRQ_RST;
		end
		else if (wb_wr)
		begin
			if (wb_adr_i == mgtp_pkg::WB_CTRL)
				ctrl_ff <= wb_dat_i[mgtp_pkg::CTRL_TEST_PORT_BIT];
			if (wb_adr_i == mgtp_pkg::WB_IRQ_MASK)
				irq_mask_ff <= wb_dat_i[2:0];
		end
	end

	// Sticky events; a new event in the clearing cycle wins over the clear.
	always_comb
	begin
		irq_evt                          = 3'h0;
		irq_evt[mgtp_pkg::IRQ_WRITE_BIT] = wr_stb_ff;
		irq_evt[mgtp_pkg::IRQ_READ_BIT]  = rd_evt_ff;
		irq_evt[mgtp_pkg::IRQ_PERR_BIT]  = perr_evt;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_stat_ff <= mgtp_pkg::IRQ_RST;
			irq_o       <= 1'b0;
		end
		else
		begin
			if (wb_wr && (wb_adr_i == mgtp_pkg::WB_IRQ_STAT))
				irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[2:0]) | irq_evt;
			else
				irq_stat_ff <= irq_stat_ff | irq_evt;
			irq_o <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_MISS_SILENT: assert property (mdio_oe_o |-> hit_ff && rd_ff)
		else $error("Data line driven for a frame that did not match.");
	AST_CHAN_ROUTE: assert property (wr_stb_ff && !core_rst && hdr_ff.regad == mgtp_pkg::REG_PWR
		|=> regs_ff[$past(hdr_ff.port[0])].pwr == $past(wdata_ff))
		else $error("Write did not reach the selected channel.");
	AST_PRBS_RESET: assert property (core_rst |=> prbs_ok_flag_oe_o && !prbs_ok_flag_o)
		else $error("Pass flag not driven low in reset.");
	AST_PRBS_FLOAT: assert property (!core_rst && (pin_pd || reg_pd) |=> !prbs_ok_flag_oe_o)
		else $error("Pass flag driven in power down.");
	AST_PRBS_SRC: assert property (prbs_ok_flag_o |-> $past(pat_any) && $past(lane_ok_s[pat_sel]))
		else $error("Pass flag high without an enabled error-free lane.");
	AST_MDIO_FLOAT: assert property (mgmt_off |=> !mdio_oe_o ##1 !mdio_oe_o)
		else $error("Data line driven in reset or pin power down.");
	AST_TDO_FLOAT: assert property (tdo_oe_o |-> $past(ctrl_ff[0] && !core_rst && !pin_pd && !reg_pd))
		else $error("Test data out driven while it must float.");
	AST_TDI_PULL: assert property (pin_pd |=> !tdi_pullup_en_o)
		else $error("Test data in pull-up on in pin power down.");
	AST_PAT_OR: assert property (pten_s && !core_rst |=> pattern_run_o == 2'h3)
		else $error("Pattern enable pin did not enable both channels.");
	AST_TA_LOW: assert property ($rose(mdio_oe_o) |-> !mdio_o)
		else $error("Second turnaround bit not driven low.");

	COV_READ: cover property (rd_evt_ff);
	COV_WRITE: cover property (wr_stb_ff);
	COV_PERR: cover property (perr_evt);
	COV_REG_PD: cover property (reg_pd && !pin_pd && mdio_oe_o);

endmodule
`default_nettype wire

// File: tb/mgtp_mdio_ctl.sv
`default_nettype none
// Station management controller; its clock rests low between frames.
module mgtp_mdio_ctl (
	// System.
	input  wire logic        clk_i,
	// Management link.
	input  wire logic        line_i,
	output logic             mdc_o,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	// Read result, second turnaround bit on top.
	output logic             done_o,
	output logic      [16:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quiet bus at time zero.
	initial
	begin
		mdc_o = 1'h0;
		mdio_o = 1'h1;
		mdio_oe_o = 1'h0;
		done_o = 1'h0;
		rdata_o = 17'h0;
	end
	// Data moves while the clock is low and is sampled just before the rise, well clear of the far end's lag.
	task automatic bit_cyc(input logic oe, input logic b, output logic s);
		@(posedge clk_i);
		mdc_o <= 1'h0;
		mdio_oe_o <= oe;
		mdio_o <= b;
		repeat (4) @(posedge clk_i);
		s = line_i;
		mdc_o <= 1'h1;
		repeat (3) @(posedge clk_i);
	endtask
	// Whole frame; a read releases the line from the first turnaround bit on.
	task automatic frame(input logic [1:0] op, input logic [4:0] port, input logic [4:0] regad,
		input logic [15:0] wdata);
		logic [13:0] hdr;
		logic [17:0] tail;
		logic        rd;
		logic        s;
		hdr = {2'h1, op, port, regad};
		tail = {2'h2, wdata};
		rd = (op == mgtp_pkg::OP_READ);
		for (int i = 0; i < 32; i++)
			bit_cyc(1'h1, 1'h1, s);
		for (int i = 13; i >= 0; i--)
			bit_cyc(1'h1, hdr[i], s);
		for (int i = 17; i >= 0; i--)
		begin
			bit_cyc(!rd, tail[i], s);
			if (i < 17)
				rdata_o[i] = s;
		end
		@(posedge clk_i);
		mdc_o <= 1'h0;
		mdio_oe_o <= 1'h0;
		done_o <= rd;
		@(posedge clk_i);
		done_o <= 1'h0;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_mgtp_mgmt_port.sv
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %0t: got %h expected %h", $time, g, e); end end
`define EXP(g, e) begin for (int w_i = 0; w_i < 40 && (g) !== (e); w_i++) @(negedge clk_i); \
	`CHK(g, e) if ((g) !== (e)) finish_test(); end
module tb_mgtp_mgmt_port;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] PORT_A = 5'h14;
	localparam logic [4:0] PORT_B = 5'h15;
	localparam logic [4:0] PORT_X = 5'h08;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, mdc_i, mdio_o, mdio_oe_o;
	logic        device_reset_low_i, power_down_chan_a_low_i, power_down_chan_b_low_i;
	logic        pattern_test_enable_i, prbs_ok_flag_o, prbs_ok_flag_oe_o, tdo_oe_o, tdi_pullup_en_o;
	logic        m_mdio, m_oe, md_done;
	logic [1:0]  pattern_run_o;
	logic [3:0]  wb_adr_i, wb_sel_i;
	logic [4:0]  port_addr_strap_i;
	logic [15:0] lane_ok_i;
	logic [16:0] md_rdata, e17;
	logic [31:0] wb_dat_i, wb_dat_o, e32, r;
	logic [31:0] seed = 32'h11f25d66;
	wire logic   mdio_i;
	int          n_mismatch = 0;
	int          num_checks = 0;
	logic [31:0] exp_wb[$];
	logic [16:0] exp_md[$];
	// Pulled-up shared data line.
	assign mdio_i = mdio_oe_o ? mdio_o : (m_oe ? m_mdio : 1'h1);
	mgtp_mgmt_port uut (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .irq_o, .device_reset_low_i, .power_down_chan_a_low_i, .power_down_chan_b_low_i,
		.pattern_test_enable_i, .port_addr_strap_i, .lane_ok_i, .mdc_i, .mdio_i, .mdio_o, .mdio_oe_o,
		.prbs_ok_flag_o, .prbs_ok_flag_oe_o, .tdo_oe_o, .tdi_pullup_en_o, .pattern_run_o
	);
	mgtp_mdio_ctl ctl (
		.clk_i, .line_i(mdio_i), .mdc_o(mdc_i), .mdio_o(m_mdio), .mdio_oe_o(m_oe),
		.done_o(md_done), .rdata_o(md_rdata)
	);
	// Free-running system clock.
	initial
	begin
		clk_i = 1'h0;
		forever
			#50 clk_i = ~clk_i;
	end
	function automatic logic [31:0] lfsr();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Request is held until ack is seen, then released at the next rising edge.
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d, input logic [3:0] sel);
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= d;
		`EXP(wb_ack_o, 1'h1)
		@(posedge clk_i);
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	task automatic wr(input logic [3:0] adr, input logic [31:0] d);
		wb(1'h1, adr, d, 4'hf);
	endtask
	task automatic rd(input logic [3:0] adr, input logic [31:0] e);
		exp_wb.push_back(e);
		wb(1'h0, adr, 32'h0, 4'hf);
	endtask
	task automatic mr(input logic [4:0] p, input logic [4:0] ra, input logic [16:0] e);
		exp_md.push_back(e);
		ctl.frame(mgtp_pkg::OP_READ, p, ra, 16'h0);
	endtask
	// Acked reads are compared against the oldest note.
	always @(negedge clk_i)
		if (wb_ack_o === 1'h1 && wb_we_i === 1'h0)
		begin
			e32 = exp_wb.pop_front();
			`CHK(wb_dat_o, e32)
		end
	// Finished management reads are compared the same way.
	always @(posedge md_done)
	begin
		e17 = exp_md.pop_front();
		`CHK(md_rdata, e17)
	end
	// Main sequence; the device reset pin stays low long past the reset hold time.
	initial
	begin
		rst_i = 1'h1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		device_reset_low_i = 1'h0;
		power_down_chan_a_low_i = 1'h1;
		power_down_chan_b_low_i = 1'h1;
		pattern_test_enable_i = 1'h0;
		port_addr_strap_i = PORT_A;
		lane_ok_i = 16'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		wr(mgtp_pkg::WB_CTRL, 32'h1);
		mr(PORT_A, mgtp_pkg::REG_PAT_EN, 17'h1ffff);
		`CHK(tdo_oe_o, 1'h0)
		`CHK(prbs_ok_flag_oe_o, 1'h1)
		`CHK(prbs_ok_flag_o, 1'h0)
		device_reset_low_i <= 1'h1;
		`EXP(tdo_oe_o, 1'h1)
		wr(mgtp_pkg::WB_CTRL, 32'h0);
		`EXP(tdo_oe_o, 1'h0)
		wb(1'h1, mgtp_pkg::WB_CTRL, 32'h1, 4'he);
		rd(mgtp_pkg::WB_CTRL, 32'h0);
		rd(4'h2, 32'h0);
		rd(mgtp_pkg::WB_STATUS, {22'h0, PORT_A, 5'h0});
		wr(mgtp_pkg::WB_IRQ_MASK, 32'h0);
		ctl.frame(mgtp_pkg::OP_WRITE, PORT_A, mgtp_pkg::REG_PAT_EN, 16'h0040);
		ctl.frame(mgtp_pkg::OP_WRITE, PORT_B, mgtp_pkg::REG_PAT_EN, 16'h1000);
		ctl.frame(mgtp_pkg::OP_WRITE, PORT_X, mgtp_pkg::REG_PAT_EN, 16'h30c0);
		mr(PORT_A, mgtp_pkg::REG_PAT_EN, 17'h00040);
		mr(PORT_B, mgtp_pkg::REG_PAT_EN, 17'h01000);
		mr(PORT_X, mgtp_pkg::REG_PAT_EN, 17'h1ffff);
		`EXP(pattern_run_o, 2'h3)
		rd(mgtp_pkg::WB_IRQ_STAT, 32'h3);
		`EXP(irq_o, 1'h0)
		wr(mgtp_pkg::WB_IRQ_MASK, 32'h2);
		`EXP(irq_o, 1'h1)
		wr(mgtp_pkg::WB_IRQ_STAT, 32'h2);
		`EXP(irq_o, 1'h0)
		ctl.frame(mgtp_pkg::OP_WRITE, PORT_B, mgtp_pkg::REG_PAT_EN, 16'h0);
		`EXP(pattern_run_o, 2'h1)
		@(posedge clk_i);
		pattern_test_enable_i <= 1'h1;
		`EXP(pattern_run_o, 2'h3)
		// The first look is timed: two sync stages plus the flag register, so an old level cannot pass it.
		for (int k = 0; k < 16; k++)
		begin
			ctl.frame(mgtp_pkg::OP_WRITE, PORT_A, mgtp_pkg::REG_PAT_SEL, 16'(k));
			r = lfsr();
			lane_ok_i <= r[15:0];
			repeat (3) @(posedge clk_i);
			@(negedge clk_i);
			`CHK(prbs_ok_flag_o, r[k])
			@(posedge clk_i);
			lane_ok_i <= ~r[15:0];
			`EXP(prbs_ok_flag_o, ~r[k])
		end
		mr(PORT_A, mgtp_pkg::REG_PAT_SEL, 17'h0000f);
		@(posedge clk_i);
		lane_ok_i <= 16'hffff;
		`EXP(prbs_ok_flag_o, 1'h1)
		wr(mgtp_pkg::WB_IRQ_STAT, 32'h7);
		wr(mgtp_pkg::WB_IRQ_MASK, 32'h4);
		lane_ok_i <= 16'h0;
		`EXP(irq_o, 1'h1)
		rd(mgtp_pkg::WB_IRQ_STAT, 32'h4);
		ctl.frame(mgtp_pkg::OP_WRITE, PORT_A, mgtp_pkg::REG_PWR, 16'h8000);
		ctl.frame(mgtp_pkg::OP_WRITE, PORT_B, mgtp_pkg::REG_PWR, 16'h8000);
		wr(mgtp_pkg::WB_CTRL, 32'h1);
		`EXP(prbs_ok_flag_oe_o, 1'h0)
		`EXP(tdi_pullup_en_o, 1'h1)
		mr(PORT_B, mgtp_pkg::REG_PWR, 17'h08000);
		`CHK(tdo_oe_o, 1'h0)
		ctl.frame(mgtp_pkg::OP_WRITE, PORT_A, mgtp_pkg::REG_PWR, 16'h0);
		`EXP(tdo_oe_o, 1'h1)
		`EXP(prbs_ok_flag_oe_o, 1'h1)
		@(posedge clk_i);
		power_down_chan_a_low_i <= 1'h0;
		power_down_chan_b_low_i <= 1'h0;
		`EXP(prbs_ok_flag_oe_o, 1'h0)
		`EXP(tdi_pullup_en_o, 1'h0)
		`EXP(tdo_oe_o, 1'h0)
		mr(PORT_A, mgtp_pkg::REG_PAT_SEL, 17'h1ffff);
		// Raise the flag first, so that only the device reset can pull it low below.
		power_down_chan_a_low_i <= 1'h1;
		lane_ok_i <= 16'hffff;
		`EXP(prbs_ok_flag_oe_o, 1'h1)
		`EXP(prbs_ok_flag_o, 1'h1)
		@(posedge clk_i);
		device_reset_low_i <= 1'h0;
		`EXP(prbs_ok_flag_o, 1'h0)
		`CHK(prbs_ok_flag_oe_o, 1'h1)
		`CHK(mdio_oe_o, 1'h0)
		finish_test();
	end
endmodule
`default_nettype wire
